//--- common/cmpc_pkg.sv
// constants and types for the current mode pulse control core
package cmpc_pkg;
   // clock
   localparam int CLK_MHZ = 100;
   // nominal switching frequency and jitter
   localparam int SW_FREQ_KHZ = 130;
   localparam int JIT_PERCENT = 4;
   localparam int JIT_DEV_HZ = 5200;
   localparam int JIT_PERIOD_MS = 4;
   localparam int CYC_NOM = (CLK_MHZ * 1000) / SW_FREQ_KHZ;
   localparam int CYC_DEV = (CYC_NOM * JIT_PERCENT) / 100;
   // duty limit 0.75 expressed as 3/4
   localparam int DMAX_NUM = 3;
   localparam int DMAX_DEN = 4;
   // jitter steps: one step of the period per switching cycle group
   localparam int JIT_STEPS = 2 * CYC_DEV;
   localparam int JIT_STEP_CYC = (JIT_PERIOD_MS * CLK_MHZ * 1000) / (2 * JIT_STEPS);
   // minimum pulse delay, least time rounds up
   localparam int MIN_DLY_NS = 156;
   localparam int MIN_DLY_CYC = (MIN_DLY_NS * CLK_MHZ + 999) / 1000;
   // leading edge blanking, least time rounds up
   localparam int BLANK_NS = 220;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   // sense amplifier gain 3.3 as 33/10
   localparam int GAIN_NUM = 33;
   localparam int GAIN_DEN = 10;
   // soft start
   localparam int SS_STEPS = 32;
   localparam int SS_STEP_US = 300;
   localparam int SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
   localparam int SS_TOTAL_MS = 10;
   localparam int SS_TOTAL_CYC = SS_TOTAL_MS * CLK_MHZ * 1000;
   localparam int ANA_W = 12;
   typedef enum logic [1:0] {CMPC_OFF, CMPC_SOFT, CMPC_RUN} cmpc_mode_e;
endpackage : cmpc_pkg

//--- logic/cmpc_core.sv
// pulse control core: oscillator, latch, blanking, soft start and supply lockout
`timescale 1ns/1ps
// Function
// R1: sensed current above feedback ends pulse
// R2: sense value scaled by gain 3.3
// R3: ramp switch closed in off phase
// R4: gate held off briefly after pulse start
// R5: ramp plus current to both comparators
// R6: soft start begins at supply turn-on
// R7: soft-start level rises in 32 equal steps
// R8: counter steps sink every 300 us
// R9: soft start ends at 10 ms, sink off
// R10: every restart reruns full soft start
// R11: 130 kHz with 4 percent jitter, 4 ms
// R12: jitter only after soft start ends
// R13: duty limited to 0.75 per cycle
// R14: oscillator sets latch, comparators reset it
// R15: latch reset turns gate off immediately
// R16: gate low while supply undervoltage
// R17: undervoltage clears soft-start counter
// R18: comparators ignored during turn-on blanking
// R19: analog status bits synchronised to clock
module cmpc_core
   import cmpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic supply_ok,
   input wire logic restart_req,
   input wire logic climit_trip,
   input wire logic [ANA_W-1:0] sense_voltage,
   input wire logic [ANA_W-1:0] ramp_voltage,
   input wire logic [ANA_W-1:0] feedback_level,
   output logic gate_drive,
   output logic ramp_reset_switch,
   output logic oscillator_phase,
   output logic [5:0] soft_start_level,
   output logic sink_enable,
   output logic soft_start_done
);
   typedef struct packed {
      logic [2:0] sok_sync;
      logic [2:0] clim_sync;
      logic [2:0] rst_sync;
      logic sok;
      cmpc_mode_e mode;
      logic [15:0] osc_cnt;
      logic [15:0] period;
      logic [15:0] on_max;
      logic [7:0] jit_pos;
      logic jit_up;
      logic [23:0] jit_div;
      logic pulse_latch;
      logic [7:0] since_set;
      logic [5:0] ss_step;
      logic [23:0] ss_div;
      logic [27:0] ss_time;
      logic gate;
      logic ramp_sw;
      logic osc_ph;
      logic sink;
      logic done;
   } cmpc_state_s;

   cmpc_state_s st_reg;
   cmpc_state_s st_next;
   logic [ANA_W+5:0] amp_sense;
   logic [ANA_W+5:0] combined;
   logic [ANA_W+5:0] ss_ref;
   logic duty_comparator;
   logic ss_comparator;
   logic blanked;
   logic sok_stable;
   logic clim_now;
   logic restart_now;

   // sense amplifier gain and the superimposed ramp [R2] [R5]
   always_comb
   begin
      amp_sense = 18'((ANA_W+6)'(sense_voltage) * (ANA_W+6)'(GAIN_NUM) / (ANA_W+6)'(GAIN_DEN));
      combined = amp_sense + (ANA_W+6)'(ramp_voltage);
      ss_ref = (ANA_W+6)'(st_reg.ss_step) << (ANA_W-5);
   end

   // comparisons are masked while the turn-on spike settles [R18]
   assign blanked = st_reg.since_set < 8'(BLANK_CYC);
   assign duty_comparator = !blanked && combined > (ANA_W+6)'(feedback_level); // [R1] [R5]
   assign ss_comparator = !blanked && st_reg.mode == CMPC_SOFT && combined > ss_ref; // [R5]
   // the first sync stage is read only by the second [R19]
   assign sok_stable = st_reg.sok_sync[1] == st_reg.sok_sync[2];
   assign clim_now = st_reg.clim_sync[1] && st_reg.clim_sync[2];
   assign restart_now = st_reg.rst_sync[1] && !st_reg.rst_sync[2];

   // next-state logic for the whole core
   always_comb
   begin
      st_next = st_reg;
      st_next.sok_sync = {st_reg.sok_sync[1:0], supply_ok}; // [R19]
      st_next.clim_sync = {st_reg.clim_sync[1:0], climit_trip};
      st_next.rst_sync = {st_reg.rst_sync[1:0], restart_req};
      if (sok_stable)
         st_next.sok = st_reg.sok_sync[2];
      // mode sequencing
      case (st_reg.mode)
         CMPC_OFF:
         begin
            if (st_reg.sok)
               st_next.mode = CMPC_SOFT; // [R6]
         end
         CMPC_SOFT:
         begin
            // a restart attempt during soft start begins it again from zero
            if (restart_now)
               st_next.mode = CMPC_OFF; // [R10]
            else if (st_reg.ss_time >= 28'(SS_TOTAL_CYC - 1))
               st_next.mode = CMPC_RUN; // [R9]
         end
         default:
         begin
            if (restart_now)
               st_next.mode = CMPC_OFF; // [R10]
         end
      endcase
      if (!st_reg.sok)
         st_next.mode = CMPC_OFF;
      // soft start counter, cleared whenever the next mode is off [R17] [R10]
      if (st_next.mode == CMPC_OFF)
      begin
         st_next.ss_step = '0;
         st_next.ss_div = '0;
         st_next.ss_time = '0;
      end
      else if (st_reg.mode == CMPC_SOFT)
      begin
         st_next.ss_time = st_reg.ss_time + 28'd1;
         if (st_reg.ss_div >= 24'(SS_STEP_CYC - 1))
         begin
            st_next.ss_div = '0;
            if (st_reg.ss_step < 6'(SS_STEPS))
               st_next.ss_step = st_reg.ss_step + 6'd1; // [R7] [R8]
         end
         else
            st_next.ss_div = st_reg.ss_div + 24'd1;
      end
      else if (st_reg.mode == CMPC_RUN)
         st_next.ss_step = 6'(SS_STEPS); // entry from off keeps the cleared count
      st_next.sink = st_next.mode == CMPC_SOFT; // [R9]
      st_next.done = st_next.mode == CMPC_RUN;
      // jitter triangle, only in normal run [R11] [R12]
      if (st_reg.mode != CMPC_RUN)
      begin
         st_next.jit_pos = 8'(CYC_DEV);
         st_next.jit_up = 1'b1;
         st_next.jit_div = '0;
      end
      else if (st_reg.jit_div >= 24'(JIT_STEP_CYC - 1))
      begin
         st_next.jit_div = '0;
         if (st_reg.jit_up)
         begin
            st_next.jit_pos = st_reg.jit_pos + 8'd1;
            if (st_reg.jit_pos >= 8'(JIT_STEPS - 1))
               st_next.jit_up = 1'b0;
         end
         else
         begin
            st_next.jit_pos = st_reg.jit_pos - 8'd1;
            if (st_reg.jit_pos <= 8'd1)
               st_next.jit_up = 1'b1;
         end
      end
      else
         st_next.jit_div = st_reg.jit_div + 24'd1;
      // oscillator; period latched at cycle start so duty limit tracks it [R11] [R13]
      if (st_reg.osc_cnt >= st_reg.period - 16'd1)
      begin
         st_next.osc_cnt = '0;
         st_next.period = 16'(CYC_NOM - CYC_DEV) + 16'(st_reg.jit_pos);
         st_next.on_max = 16'((32'(16'(CYC_NOM - CYC_DEV) + 16'(st_reg.jit_pos)) * DMAX_NUM) / DMAX_DEN);
      end
      else
         st_next.osc_cnt = st_reg.osc_cnt + 16'd1;
      st_next.osc_ph = st_next.osc_cnt < st_next.on_max;
      st_next.ramp_sw = !st_next.osc_ph; // [R3]
      // pulse latch: set at cycle start, set wins over a reset in the same cycle [R14]
      if (st_next.osc_cnt == '0 && st_reg.mode != CMPC_OFF)
      begin
         st_next.pulse_latch = 1'b1;
         st_next.since_set = '0;
      end
      else
      begin
         if (st_reg.since_set != 8'hFF)
            st_next.since_set = st_reg.since_set + 8'd1;
         if (duty_comparator || ss_comparator || (clim_now && !blanked) || !st_next.osc_ph)
            st_next.pulse_latch = 1'b0; // [R1] [R13] [R14]
      end
      // gate needs latch, minimum delay and good supply [R4] [R15] [R16]
      st_next.gate = st_next.pulse_latch && st_next.mode != CMPC_OFF
                     && st_next.since_set >= 8'(MIN_DLY_CYC);
   end

   // single state register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '0;
         st_reg.mode <= CMPC_OFF;
         st_reg.period <= 16'(CYC_NOM);
         st_reg.on_max <= 16'((CYC_NOM * DMAX_NUM) / DMAX_DEN);
         st_reg.ramp_sw <= 1'b1;
         st_reg.jit_pos <= 8'(CYC_DEV);
      end
      else
         st_reg <= st_next;
   end

   assign gate_drive = st_reg.gate;
   assign ramp_reset_switch = st_reg.ramp_sw;
   assign oscillator_phase = st_reg.osc_ph;
   assign soft_start_level = st_reg.ss_step;
   assign sink_enable = st_reg.sink;
   assign soft_start_done = st_reg.done;

   property p_uv_gate;
      @(posedge clk) disable iff (rst) !st_reg.sok |=> !gate_drive;
   endproperty
   a_uv_gate: assert property (p_uv_gate) else $error("gate on under undervoltage"); // [R16]

   property p_uv_clear;
      @(posedge clk) disable iff (rst) !st_reg.sok |=> soft_start_level == 6'h00;
   endproperty
   a_uv_clear: assert property (p_uv_clear) else $error("soft start not cleared"); // [R17]

   property p_gate_latch;
      @(posedge clk) disable iff (rst) gate_drive |-> st_reg.pulse_latch;
   endproperty
   a_gate_latch: assert property (p_gate_latch) else $error("gate without latch"); // [R15]

   property p_min_dly;
      @(posedge clk) disable iff (rst) $rose(st_reg.pulse_latch) |-> !gate_drive [*8];
   endproperty
   a_min_dly: assert property (p_min_dly) else $error("gate too early"); // [R4]

   property p_ramp_sw;
      @(posedge clk) disable iff (rst) ramp_reset_switch != oscillator_phase;
   endproperty
   a_ramp_sw: assert property (p_ramp_sw) else $error("ramp switch wrong"); // [R3]

   property p_duty;
      @(posedge clk) disable iff (rst) gate_drive |-> st_reg.osc_cnt < st_reg.on_max;
   endproperty
   a_duty: assert property (p_duty) else $error("duty limit exceeded"); // [R13]

   property p_sink;
      @(posedge clk) disable iff (rst) soft_start_done |-> !sink_enable;
   endproperty
   a_sink: assert property (p_sink) else $error("sink on after soft start"); // [R9]

   property p_step;
      @(posedge clk) disable iff (rst) st_reg.mode == CMPC_SOFT && $past(st_reg.mode) == CMPC_SOFT
         |-> soft_start_level - $past(soft_start_level) <= 6'h01;
   endproperty
   a_step: assert property (p_step) else $error("soft start jumped"); // [R7]

   property p_nojit;
      @(posedge clk) disable iff (rst) !$past(soft_start_done) |-> st_reg.jit_pos == 8'(CYC_DEV)
         && st_reg.jit_div == '0;
   endproperty
   a_nojit: assert property (p_nojit) else $error("jitter during soft start"); // [R12]

   // a pulse may only end once blanking is over or at the duty limit
   property p_blank;
      @(posedge clk) disable iff (rst) $fell(st_reg.pulse_latch)
         |-> st_reg.since_set > 8'(BLANK_CYC) || !oscillator_phase;
   endproperty
   a_blank: assert property (p_blank) else $error("pulse ended inside blanking"); // [R18]

   property p_period;
      @(posedge clk) disable iff (rst) st_reg.osc_cnt < st_reg.period
         && st_reg.period >= 16'(CYC_NOM - CYC_DEV) && st_reg.period <= 16'(CYC_NOM + CYC_DEV);
   endproperty
   a_period: assert property (p_period) else $error("switching period out of band"); // [R11]

   property p_ss_max;
      @(posedge clk) disable iff (rst) soft_start_level <= 6'(SS_STEPS);
   endproperty
   a_ss_max: assert property (p_ss_max) else $error("soft start level beyond last step"); // [R7]

   property p_restart;
      @(posedge clk) disable iff (rst) restart_now && st_reg.mode != CMPC_OFF |=> st_reg.mode == CMPC_OFF;
   endproperty
   a_restart: assert property (p_restart) else $error("restart attempt ignored"); // [R10]

   property p_sync;
      @(posedge clk) disable iff (rst) !sok_stable |=> st_reg.sok == $past(st_reg.sok);
   endproperty
   a_sync: assert property (p_sync) else $error("supply status taken while unsettled"); // [R19]

   property p_gate_mode;
      @(posedge clk) disable iff (rst) gate_drive |-> st_reg.mode != CMPC_OFF;
   endproperty
   a_gate_mode: assert property (p_gate_mode) else $error("gate on while switched off"); // [R16]

   property p_latch_set;
      @(posedge clk) disable iff (rst) st_reg.osc_cnt == 16'h0000 && $past(st_reg.mode) != CMPC_OFF
         |-> st_reg.pulse_latch;
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch not set at cycle start"); // [R14]
endmodule : cmpc_core

//--- bench/cmpc_gate_model.sv
// switch and sense resistor model driven by the gate output
`timescale 1ns/1ps
module cmpc_gate_model
   import cmpc_pkg::*;
#(
   parameter int SLOPE = 1
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic gate_drive,
   output logic [ANA_W-1:0] sense_voltage
);
   // current ramps while on; switch off means no current, so the pin sits at ground
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sense_voltage <= 12'h000;
      else if (gate_drive)
         sense_voltage <= sense_voltage + SLOPE[ANA_W-1:0];
      else
         sense_voltage <= 12'h000;
   end
endmodule : cmpc_gate_model

//--- bench/tb.sv
// self-checking bench for the pulse control core
`timescale 1ns/1ps
`define CHK(a, b) \
   begin comparisons++; if ((a) !== (b)) begin mismatches++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb
   import cmpc_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, supply_ok = 1'b0, restart_req = 1'b0, climit_trip = 1'b0;
   logic [ANA_W-1:0] sense_voltage, ramp_voltage = 12'h000, feedback_level = 12'hFFF;
   logic gate_drive, ramp_reset_switch, oscillator_phase, sink_enable, soft_start_done;
   logic [5:0] soft_start_level;
   int mismatches = 0, comparisons = 0, cyc = 0, t0, r, w, w1, n;
   cmpc_core cmpc_core_i (.clk(clk), .rst(rst), .supply_ok(supply_ok), .restart_req(restart_req),
      .climit_trip(climit_trip), .sense_voltage(sense_voltage), .ramp_voltage(ramp_voltage),
      .feedback_level(feedback_level), .gate_drive(gate_drive), .ramp_reset_switch(ramp_reset_switch),
      .oscillator_phase(oscillator_phase), .soft_start_level(soft_start_level),
      .sink_enable(sink_enable), .soft_start_done(soft_start_done));
   cmpc_gate_model cmpc_gate_model_i (.clk(clk), .rst(rst), .gate_drive(gate_drive),
      .sense_voltage(sense_voltage));
   always #5 clk = ~clk;
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   // two soft-start steps dominate the run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 75000)
      begin
         mismatches++;
         end_sim();
      end
   end
   // cycles to the next cycle start; a call begun at a start spans one period
   task automatic next_start(output int k);
      for (k = 0; oscillator_phase !== 1'b0 && k < 1000; k++) @(negedge clk);
      for (k = k; oscillator_phase !== 1'b1 && k < 2000; k++) @(negedge clk);
   endtask : next_start
   // delay to gate on and on-time of the next pulse
   task automatic pulse(output int rise, output int wid);
      next_start(n);
      for (rise = 0; gate_drive !== 1'b1 && rise < 800; rise++) @(negedge clk);
      for (wid = 0; gate_drive !== 1'b0 && wid < 800; wid++) @(negedge clk);
   endtask : pulse
   task automatic t_reset;
      @(negedge clk);
      `CHK({gate_drive, ramp_reset_switch, sink_enable, soft_start_done, soft_start_level}, 10'h100)
      @(posedge clk) rst <= 1'b0;
      n = 0;
      repeat (1600) @(negedge clk) n += gate_drive;
      `CHK(n, 0)
   endtask : t_reset
   task automatic t_start;
      @(posedge clk) supply_ok <= 1'b1;
      for (n = 0; sink_enable !== 1'b1 && n < 20; n++) @(negedge clk);
      t0 = cyc;
      `CHK({sink_enable, soft_start_done, soft_start_level}, 8'h80)
   endtask : t_start
   task automatic t_osc;
      next_start(n);
      next_start(n);
      `CHK(n, CYC_NOM)
      for (n = 0; oscillator_phase === 1'b1 && n < 1000; n++) @(negedge clk);
      `CHK(n >= 576 && n <= 577, 1'b1)
      `CHK({oscillator_phase, ramp_reset_switch}, 2'b01)
      pulse(r, w);
      `CHK({oscillator_phase, ramp_reset_switch}, 2'b10)
      `CHK(r >= MIN_DLY_CYC - 1, 1'b1)
      `CHK(r + w >= BLANK_CYC && w < 12, 1'b1)
   endtask : t_osc
   task automatic t_steps;
      for (n = 0; soft_start_level !== 6'h01 && n < 31000; n++) @(negedge clk);
      `CHK(cyc - t0 >= SS_STEP_CYC - 5 && cyc - t0 <= SS_STEP_CYC + 5, 1'b1)
      t0 = cyc;
      for (n = 0; soft_start_level !== 6'h02 && n < 31000; n++) @(negedge clk);
      `CHK(cyc - t0 >= SS_STEP_CYC - 2 && cyc - t0 <= SS_STEP_CYC + 2, 1'b1)
   endtask : t_steps
   task automatic t_trip;
      pulse(r, w1);
      `CHK(w1 >= 72 && w1 <= 86, 1'b1)
      @(posedge clk) feedback_level <= 12'h040;
      pulse(r, w);
      `CHK(w < w1 - 30, 1'b1)
      @(posedge clk) feedback_level <= 12'hFFF;
      ramp_voltage <= 12'h080;
      pulse(r, w);
      `CHK(w < w1 - 20, 1'b1)
      @(posedge clk) ramp_voltage <= 12'h000;
      next_start(n);
      for (n = 0; gate_drive !== 1'b1 && n < 800; n++) @(negedge clk);
      repeat (10) @(posedge clk);
      climit_trip <= 1'b1;
      for (n = 0; gate_drive !== 1'b0 && n < 800; n++) @(negedge clk);
      `CHK(n <= 7, 1'b1)
      @(posedge clk) climit_trip <= 1'b0;
   endtask : t_trip
   task automatic t_restart;
      // supply loss at step 2 must clear the count and hold the gate low
      @(posedge clk) supply_ok <= 1'b0;
      repeat (12) @(negedge clk);
      `CHK({gate_drive, sink_enable, soft_start_level}, 8'h00)
      @(posedge clk) supply_ok <= 1'b1;
      for (n = 0; sink_enable !== 1'b1 && n < 20; n++) @(negedge clk);
      `CHK({sink_enable, soft_start_done, soft_start_level}, 8'h80)
      // a restart shows as one cycle with the sink released
      @(posedge clk) restart_req <= 1'b1;
      w = 0;
      repeat (12) @(negedge clk) w += (sink_enable === 1'b0);
      @(posedge clk) restart_req <= 1'b0;
      `CHK(w, 1)
      repeat (30) @(negedge clk);
      `CHK({sink_enable, soft_start_done, soft_start_level}, 8'h80)
   endtask : t_restart
   initial
   begin
      repeat (2) @(posedge clk);
      t_reset();
      t_start();
      t_osc();
      t_steps();
      t_trip();
      t_restart();
      end_sim();
   end
endmodule : tb
